// ### inc/edm_pkg.sv
// Purpose: constants for the external data memory interface
// Assumes: 8-bit special-function register port, 200 MHz MCLK
// Notes:   register codes for timing and page are locally chosen
package edm_pkg;
    // special-function register addresses
    localparam logic [7:0] CFG_ADDR  = 8'hA3;
    localparam logic [7:0] PAGE_ADDR = 8'hA2;
    localparam logic [7:0] TC_ADDR   = 8'hA1;
    // reset values
    localparam logic [7:0] CFG_RESET  = 8'h00;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] TC_RESET   = 8'hFF;
    // configuration fields
    localparam int CFG_MUX_BIT = 4;
    localparam int CFG_MODE_HI = 3;
    localparam int CFG_MODE_LO = 2;
    localparam int CFG_ALE_HI  = 1;
    localparam int CFG_ALE_LO  = 0;
    localparam logic [7:0] CFG_RD_MASK = 8'h1F;
    // timing fields
    localparam int TC_SET_HI = 7;
    localparam int TC_SET_LO = 6;
    localparam int TC_STB_HI = 5;
    localparam int TC_STB_LO = 2;
    localparam int TC_HLD_HI = 1;
    localparam int TC_HLD_LO = 0;
    // address map
    localparam int              ON_CHIP_XDATA_RAM_AW    = 12;
    localparam logic [15:0]     ONCHIP_TOP = 16'h1000;
    localparam logic [1:0] MODE_INT   = 2'h0;
    localparam logic [1:0] MODE_SPLIT = 2'h1;
    localparam logic [1:0] MODE_BANK  = 2'h2;
    localparam logic [1:0] MODE_EXT   = 2'h3;
    // fixed overhead: one start cycle plus these end cycles
    localparam logic [3:0] END_CYC   = 4'h3;
    localparam int         OVERHEAD  = 4;
    localparam logic [3:0] ZERO4     = 4'h0;
    localparam logic [3:0] ONE4      = 4'h1;

    typedef enum logic [2:0] {
        S_IDLE, S_START, S_ALEH, S_ALEL, S_SETUP, S_STROBE, S_HOLD, S_END
    } edm_state_e;
endpackage

// ### src/edm_pin_sync.sv
// Purpose: three-stage sampler for asynchronous pin inputs
// Assumes: value accepted once stages two and three agree
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module edm_pin_sync #(
    parameter int W = 8
) (
    input  wire logic         MCLK,
    input  wire logic         RST_N,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
        end else if (s2_r == s3_r) begin
            q <= s3_r;
        end
    end
endmodule
`default_nettype wire

// ### src/edm_on_chip_xdata_ram.sv
// Purpose: on-chip data RAM, byte wide
// Assumes: write on the clock edge, read combinational
// Notes:   address already reduced to the populated space
`timescale 1ns/1ps
`default_nettype none
module edm_on_chip_xdata_ram
    import edm_pkg::*;
(
    input  wire logic               MCLK,
    input  wire logic               we,
    input  wire logic [ON_CHIP_XDATA_RAM_AW-1:0] addr,
    input  wire logic [7:0]         wdata,
    output logic      [7:0]         rdata
);
    logic [7:0] mem [0:(1<<ON_CHIP_XDATA_RAM_AW)-1];

    always_ff @(posedge MCLK) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];
endmodule
`default_nettype wire

// ### src/edm_top.sv
// Purpose: external data memory interface with on-chip RAM steering
// Assumes: one access at a time, taken while CPU_BUSY is low
// Notes:   timing fields are sampled when an access is taken
// Function
// [RULE_01] config bit four picks multiplexed bus
// [RULE_02] muxed: low address and data share pins
// [RULE_03] latch strobe high with low address first
// [RULE_04] latch strobe falls, then data under strobe
// [RULE_05] external latch follows high, holds after fall
// [RULE_06] non-muxed: separate pins, no latch phase
// [RULE_07] mode 00: all on-chip, wraps at 4k
// [RULE_08] 8-bit internal: page high, register low
// [RULE_09] 16-bit internal: data pointer address
// [RULE_10] mode 01: below 4k on-chip, else off
// [RULE_11] split no bank: high lines undriven
// [RULE_12] split 16-bit: pointer decides, all lines
// [RULE_13] mode 10: page drives high address lines
// [RULE_14] mode 11: everything off-chip, RAM hidden
// [RULE_15] external only: page ignored, high undriven
// [RULE_16] setup, hold, strobes, latch programmable
// [RULE_17] access lasts fields plus four cycles
// [RULE_18] muxed latch phase adds at least two
// [RULE_19] timing register resets to all ones
// [RULE_20] strobe lasts field plus one cycles
// [RULE_21] two-bit setup and hold cycle counts
// [RULE_22] latch code sets high/low time 1-4
// [RULE_23] address, setup, strobe, hold in order
// [RULE_24] memory drives read data before release
`timescale 1ns/1ps
`default_nettype none
module edm_top (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // special-function register port
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WE,
    input  wire logic [7:0]  SFR_WDATA,
    output logic      [7:0]  SFR_RDATA,
    // cpu access port
    input  wire logic        CPU_REQ,
    input  wire logic        CPU_WR,
    input  wire logic        CPU_WIDE,
    input  wire logic [7:0]  CPU_RI,
    input  wire logic [15:0] CPU_DATA_POINTER,
    input  wire logic [7:0]  CPU_WDATA,
    output logic      [7:0]  CPU_RDATA,
    output logic             CPU_DONE,
    output logic             CPU_BUSY,
    // external memory pins
    output logic      [7:0]  ADDR_HI_O,
    output logic             ADDR_HI_OE,
    output logic      [7:0]  ADDR_LO_O,
    output logic             ADDR_LO_OE,
    output logic      [7:0]  DATA_O,
    output logic             DATA_OE,
    input  wire logic [7:0]  DATA_I,
    output logic             ALE,
    output logic             RD_N,
    output logic             WR_N
);
    import edm_pkg::*;

    logic [7:0]       cfg_r;
    logic [7:0]       page_r;
    logic [7:0]       tc_r;
    edm_state_e       state_r;
    edm_state_e       state_nxt;
    logic [3:0]       cnt_r;
    logic [3:0]       cnt_nxt;
    logic [15:0]      addr_r;
    logic [7:0]       wdata_r;
    logic             wr_r;
    logic             hi_drv_r;
    logic             mux_r;
    logic [1:0]       ale_w_r;
    logic [7:0]       lat_tc_r;
    logic             int_done_r;
    logic [15:0]      eff_addr;
    logic             off_chip;
    logic             take;
    logic             mux_now;
    logic [1:0]       mode;
    logic [7:0]       on_chip_xdata_ram_rdata;
    logic [7:0]       pin_data;
    logic             ext_done;
    logic             strobe_last;
    logic             drv_phase;
    logic             load;
    logic [15:0]      addr_use;
    logic             hi_use;
    logic             mux_use;

    function automatic logic [3:0] stb_cnt(input logic [7:0] tc);
        stb_cnt = tc[TC_STB_HI:TC_STB_LO];
    endfunction

    function automatic logic [3:0] fld2(input logic [1:0] f);
        fld2 = {2'h0, f};
    endfunction

    assign mode    = cfg_r[CFG_MODE_HI:CFG_MODE_LO];
    assign mux_now = ~cfg_r[CFG_MUX_BIT]; // RULE_01
    // effective address: pointer or page:register
    assign eff_addr = CPU_WIDE ? CPU_DATA_POINTER : {page_r, CPU_RI}; // RULE_08 RULE_09

    always_comb begin
        unique case (mode)
            MODE_INT:   off_chip = 1'b0; // RULE_07
            MODE_SPLIT,
            MODE_BANK:  off_chip = eff_addr >= ONCHIP_TOP; // RULE_10 RULE_12
            MODE_EXT:   off_chip = 1'b1; // RULE_14
        endcase
    end

    assign take     = CPU_REQ && !CPU_BUSY;
    assign CPU_BUSY = (state_r != S_IDLE) || int_done_r;
    assign ext_done = (state_r == S_END) && (cnt_r == ZERO4);
    assign CPU_DONE = ext_done || int_done_r;
    assign strobe_last = (state_r == S_STROBE) && (cnt_r == ZERO4);

    // register port
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_r  <= CFG_RESET;
            page_r <= PAGE_RESET;
            tc_r   <= TC_RESET; // RULE_19
        end else if (SFR_WE) begin
            if (SFR_ADDR == CFG_ADDR) begin
                cfg_r <= SFR_WDATA & CFG_RD_MASK;
            end
            if (SFR_ADDR == PAGE_ADDR) begin
                page_r <= SFR_WDATA;
            end
            if (SFR_ADDR == TC_ADDR) begin
                tc_r <= SFR_WDATA; // RULE_16
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            SFR_RDATA <= 8'h00;
        end else begin
            unique case (SFR_ADDR)
                CFG_ADDR:  SFR_RDATA <= cfg_r;
                PAGE_ADDR: SFR_RDATA <= page_r;
                TC_ADDR:   SFR_RDATA <= tc_r;
                default:   SFR_RDATA <= 8'h00;
            endcase
        end
    end

    // on-chip RAM, index wraps at the populated size
    edm_on_chip_xdata_ram u_on_chip_xdata_ram (
        .MCLK  (MCLK),
        .we    (take && !off_chip && CPU_WR),
        .addr  (eff_addr[ON_CHIP_XDATA_RAM_AW-1:0]), // RULE_07
        .wdata (CPU_WDATA),
        .rdata (on_chip_xdata_ram_rdata)
    );

    edm_pin_sync #(.W(8)) u_sync (
        .MCLK  (MCLK),
        .RST_N (RST_N),
        .d     (DATA_I),
        .q     (pin_data)
    );

    // access snapshot
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            addr_r   <= 16'h0000;
            wdata_r  <= 8'h00;
            wr_r     <= 1'b0;
            hi_drv_r <= 1'b0;
            mux_r    <= 1'b0;
            ale_w_r  <= 2'h0;
            lat_tc_r <= TC_RESET;
        end else if (take && off_chip) begin
            addr_r   <= eff_addr;
            wdata_r  <= CPU_WDATA;
            wr_r     <= CPU_WR;
            // high lines only for 16-bit or banked access
            hi_drv_r <= CPU_WIDE || (mode == MODE_BANK); // RULE_11 RULE_13 RULE_15
            mux_r    <= mux_now;
            ale_w_r  <= cfg_r[CFG_ALE_HI:CFG_ALE_LO]; // RULE_22
            lat_tc_r <= tc_r;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            int_done_r <= 1'b0;
        end else begin
            int_done_r <= take && !off_chip;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            CPU_RDATA <= 8'h00;
        end else if (take && !off_chip && !CPU_WR) begin
            CPU_RDATA <= on_chip_xdata_ram_rdata;
        end else if (strobe_last && !wr_r) begin
            CPU_RDATA <= pin_data; // RULE_24
        end
    end

    // access sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (state_r != S_IDLE && cnt_r != ZERO4) begin
            cnt_nxt = cnt_r - ONE4;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (take && off_chip) begin
                        state_nxt = S_START;
                        cnt_nxt   = ZERO4;
                    end
                end
                S_START, S_ALEL: begin
                    if (state_r == S_START && mux_r) begin
                        state_nxt = S_ALEH; // RULE_03 RULE_18
                        cnt_nxt   = fld2(ale_w_r); // RULE_22
                    end else if (lat_tc_r[TC_SET_HI:TC_SET_LO] != 2'h0) begin
                        state_nxt = S_SETUP; // RULE_21 RULE_23
                        cnt_nxt   = fld2(lat_tc_r[TC_SET_HI:TC_SET_LO]) - ONE4;
                    end else begin
                        state_nxt = S_STROBE;
                        cnt_nxt   = stb_cnt(lat_tc_r);
                    end
                end
                S_ALEH: begin
                    state_nxt = S_ALEL; // RULE_04
                    cnt_nxt   = fld2(ale_w_r); // RULE_22
                end
                S_SETUP: begin
                    state_nxt = S_STROBE;
                    cnt_nxt   = stb_cnt(lat_tc_r); // RULE_20
                end
                S_STROBE: begin
                    if (lat_tc_r[TC_HLD_HI:TC_HLD_LO] != 2'h0) begin
                        state_nxt = S_HOLD; // RULE_21 RULE_23
                        cnt_nxt   = fld2(lat_tc_r[TC_HLD_HI:TC_HLD_LO]) - ONE4;
                    end else begin
                        state_nxt = S_END;
                        cnt_nxt   = END_CYC - ONE4;
                    end
                end
                S_HOLD: begin
                    state_nxt = S_END; // RULE_17
                    cnt_nxt   = END_CYC - ONE4;
                end
                S_END: begin
                    state_nxt = S_IDLE;
                    cnt_nxt   = ZERO4;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= S_IDLE;
            cnt_r   <= ZERO4;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // pin drivers, registered from the next state
    assign drv_phase = (state_nxt != S_IDLE) && (state_nxt != S_END);
    // first access cycle must not show the previous access's snapshot
    assign load     = take && off_chip;
    assign addr_use = load ? eff_addr : addr_r;
    assign hi_use   = load ? (CPU_WIDE || (mode == MODE_BANK)) : hi_drv_r;
    assign mux_use  = load ? mux_now : mux_r;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ALE  <= 1'b0;
            RD_N <= 1'b1;
            WR_N <= 1'b1;
        end else begin
            ALE  <= state_nxt == S_ALEH; // RULE_03 RULE_06
            RD_N <= !(state_nxt == S_STROBE && !wr_r); // RULE_20
            WR_N <= !(state_nxt == S_STROBE && wr_r); // RULE_20
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ADDR_HI_O  <= 8'h00;
            ADDR_HI_OE <= 1'b0;
            ADDR_LO_O  <= 8'h00;
            ADDR_LO_OE <= 1'b0;
        end else begin
            ADDR_HI_O  <= addr_use[15:8]; // RULE_12 RULE_13
            ADDR_HI_OE <= drv_phase && hi_use; // RULE_11 RULE_15
            ADDR_LO_O  <= addr_use[7:0];
            ADDR_LO_OE <= drv_phase && !mux_use; // RULE_06
        end
    end

    // shared pins: low address during latch phase, then data
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            DATA_O  <= 8'h00;
            DATA_OE <= 1'b0;
        end else if (mux_use && (state_nxt == S_START ||
                                 state_nxt == S_ALEH ||
                                 state_nxt == S_ALEL)) begin
            DATA_O  <= addr_use[7:0]; // RULE_02 RULE_03
            DATA_OE <= 1'b1;
        end else begin
            DATA_O  <= wdata_r; // RULE_04
            DATA_OE <= wr_r && (state_nxt == S_SETUP ||
                                state_nxt == S_STROBE ||
                                state_nxt == S_HOLD);
        end
    end

    // helper counters for the checks below
    logic [6:0] len_r;
    logic [4:0] stb_len_r;
    logic       seen_r;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            len_r     <= 7'h00;
            stb_len_r <= 5'h00;
            seen_r    <= 1'b0;
        end else begin
            len_r     <= (state_r == S_IDLE) ? 7'h00 : len_r + 7'h01;
            stb_len_r <= (!RD_N || !WR_N) ? stb_len_r + 5'h01 : 5'h00;
            seen_r    <= 1'b1;
        end
    end

    property p_tc_reset;
        @(posedge MCLK) disable iff (!RST_N)
        !seen_r |-> tc_r == TC_RESET;
    endproperty
    a_tc_reset: assert property (p_tc_reset) // RULE_19
        else $error("timing register not all ones after reset");

    property p_ale_addr;
        @(posedge MCLK) disable iff (!RST_N)
        ALE |-> DATA_OE && DATA_O == addr_r[7:0] && !ADDR_LO_OE;
    endproperty
    a_ale_addr: assert property (p_ale_addr) // RULE_03
        else $error("latch strobe high without low address");

    property p_no_ale;
        @(posedge MCLK) disable iff (!RST_N)
        (state_r != S_IDLE && !mux_r) |-> !ALE;
    endproperty
    a_no_ale: assert property (p_no_ale) // RULE_06
        else $error("latch strobe in non-multiplexed access");

    property p_wr_data;
        @(posedge MCLK) disable iff (!RST_N)
        !WR_N |-> DATA_OE && DATA_O == wdata_r && !ALE;
    endproperty
    a_wr_data: assert property (p_wr_data) // RULE_04
        else $error("write strobe without data on the bus");

    property p_ale_low;
        @(posedge MCLK) disable iff (!RST_N)
        $fell(ALE) |-> !ALE [*1] ##0 (RD_N && WR_N);
    endproperty
    a_ale_low: assert property (p_ale_low) // RULE_22
        else $error("strobe overlaps latch low time start");

    property p_internal;
        @(posedge MCLK) disable iff (!RST_N)
        (take && mode == MODE_INT) |=> state_r == S_IDLE && int_done_r;
    endproperty
    a_internal: assert property (p_internal) // RULE_07
        else $error("internal-only access went off-chip");

    property p_ext_only;
        @(posedge MCLK) disable iff (!RST_N)
        (take && mode == MODE_EXT) |=> state_r == S_START;
    endproperty
    a_ext_only: assert property (p_ext_only) // RULE_14
        else $error("external-only access stayed on-chip");

    property p_hi_lines;
        @(posedge MCLK) disable iff (!RST_N)
        (take && off_chip && !CPU_WIDE && mode != MODE_BANK)
        |-> ##1 !ADDR_HI_OE [*4];
    endproperty
    a_hi_lines: assert property (p_hi_lines) // RULE_11
        else $error("high address lines driven without bank");

    property p_bank;
        @(posedge MCLK) disable iff (!RST_N)
        (take && off_chip && !CPU_WIDE && mode == MODE_BANK)
        |-> ##2 ADDR_HI_OE && ADDR_HI_O == $past(page_r, 2);
    endproperty
    a_bank: assert property (p_bank) // RULE_13
        else $error("bank page missing on high address lines");

    property p_strobe_len;
        @(posedge MCLK) disable iff (!RST_N)
        ($rose(RD_N) || $rose(WR_N))
        |-> stb_len_r == {1'b0, stb_cnt(lat_tc_r)} + 5'h01;
    endproperty
    a_strobe_len: assert property (p_strobe_len) // RULE_20
        else $error("strobe width differs from field plus one");

    property p_access_len;
        @(posedge MCLK) disable iff (!RST_N)
        ext_done |-> len_r + 7'h01 == 7'(OVERHEAD)
            + {5'h00, lat_tc_r[TC_SET_HI:TC_SET_LO]}
            + {3'h0, stb_cnt(lat_tc_r)} + 7'h01
            + {5'h00, lat_tc_r[TC_HLD_HI:TC_HLD_LO]}
            + (mux_r ? {4'h0, ale_w_r, 1'b0} + 7'h02 : 7'h00);
    endproperty
    a_access_len: assert property (p_access_len) // RULE_17 RULE_18
        else $error("off-chip access length is wrong");
endmodule
`default_nettype wire

// ### tb/edm_sram_model.sv
// Purpose: external byte memory with optional low address latch
// Assumes: undriven high address lines rest at PORT_HI
// Notes:   released data lines show a pattern changing every cycle
`timescale 1ns/1ps
`default_nettype none
module edm_sram_model #(
    parameter logic [7:0] PORT_HI = 8'hEE
) (
    // interface pins
    input  wire logic        mclk,
    input  wire logic        muxed,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [7:0]  a_hi,
    input  wire logic        a_hi_oe,
    input  wire logic [7:0]  a_lo,
    input  wire logic [7:0]  d_out,
    // returned data and observed address
    output logic      [7:0]  d_in,
    output logic      [15:0] seen_addr
);
    logic [7:0]  mem [65536];
    logic [7:0]  low_q;
    logic [7:0]  junk = 8'h5A;
    logic [15:0] addr;

    // latch follows while high, holds after fall
    always_latch begin
        if (ale) begin
            low_q <= d_out;
        end
    end

    assign addr = {a_hi_oe ? a_hi : PORT_HI, muxed ? low_q : a_lo};

    always_ff @(posedge mclk) begin
        junk <= junk + 8'h3B;
        if (!wr_n) begin
            mem[addr] <= d_out;
        end
        if (!wr_n || !rd_n) begin
            seen_addr <= addr;
        end
    end

    assign d_in = rd_n ? junk : mem[addr];
endmodule
`default_nettype wire

// ### tb/edm_top_tb.sv
// Purpose: self-checking bench for the external memory interface
// Assumes: partner memory model on the pins
// Notes:   access length measured from take edge to done
`timescale 1ns/1ps
`default_nettype none
module edm_top_tb;
    import edm_pkg::*;
    typedef struct packed {
        logic [7:0]  cfg;
        logic        wide;
        logic [15:0] aw;
        logic [15:0] ar;
        logic        off;
        logic [15:0] ea;
    } edm_row_s;
    localparam edm_row_s ROWS [8] = '{
        '{8'h00, 1'b0, 16'h0034, 16'h0034, 1'b0, 16'h0000},
        '{8'h00, 1'b1, 16'h1005, 16'h0005, 1'b0, 16'h0000},
        '{8'h14, 1'b1, 16'h0123, 16'h0123, 1'b0, 16'h0000},
        '{8'h14, 1'b1, 16'h2345, 16'h2345, 1'b1, 16'h2345},
        '{8'h04, 1'b0, 16'h0056, 16'h0056, 1'b1, 16'hEE56},
        '{8'h18, 1'b0, 16'h0078, 16'h0078, 1'b1, 16'h2078},
        '{8'h0C, 1'b0, 16'h009A, 16'h009A, 1'b1, 16'hEE9A},
        '{8'h1C, 1'b1, 16'h0BCD, 16'h0BCD, 1'b1, 16'h0BCD}};
    localparam logic [7:0] TT [5] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'hC2};
    localparam logic [7:0] TF [5] = '{8'h0C, 8'h1C, 8'h0C, 8'h0F, 8'h1C};
    localparam int         TN [5] = '{28, 5, 7, 13, 10};
    localparam int         TS [5] = '{16, 1, 1, 1, 1};
    localparam int         TL [5] = '{1, 0, 1, 4, 0};

    logic        MCLK = 1'b0;
    logic        RST_N = 1'b0;
    logic [7:0]  SFR_ADDR = 8'h00;
    logic        SFR_WE = 1'b0;
    logic [7:0]  SFR_WDATA = 8'h00;
    logic [7:0]  SFR_RDATA;
    logic        CPU_REQ = 1'b0;
    logic        CPU_WR = 1'b0;
    logic        CPU_WIDE = 1'b0;
    logic [7:0]  CPU_RI = 8'h00;
    logic [15:0] CPU_DATA_POINTER = 16'h0000;
    logic [7:0]  CPU_WDATA = 8'h00;
    logic [7:0]  CPU_RDATA;
    logic        CPU_DONE;
    logic        CPU_BUSY;
    logic [7:0]  ADDR_HI_O;
    logic        ADDR_HI_OE;
    logic [7:0]  ADDR_LO_O;
    logic        ADDR_LO_OE;
    logic [7:0]  DATA_O;
    logic        DATA_OE;
    logic [7:0]  DATA_I;
    logic        ALE;
    logic        RD_N;
    logic        WR_N;
    logic        muxed = 1'b1;
    logic [15:0] seen_addr;
    int          miscompares = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          stb_cnt = 0;
    int          ale_cnt = 0;

    edm_top i_dut (.MCLK(MCLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
        .SFR_WE(SFR_WE), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
        .CPU_REQ(CPU_REQ), .CPU_WR(CPU_WR), .CPU_WIDE(CPU_WIDE),
        .CPU_RI(CPU_RI), .CPU_DATA_POINTER(CPU_DATA_POINTER), .CPU_WDATA(CPU_WDATA),
        .CPU_RDATA(CPU_RDATA), .CPU_DONE(CPU_DONE), .CPU_BUSY(CPU_BUSY),
        .ADDR_HI_O(ADDR_HI_O), .ADDR_HI_OE(ADDR_HI_OE),
        .ADDR_LO_O(ADDR_LO_O), .ADDR_LO_OE(ADDR_LO_OE), .DATA_O(DATA_O),
        .DATA_OE(DATA_OE), .DATA_I(DATA_I), .ALE(ALE), .RD_N(RD_N),
        .WR_N(WR_N));

    edm_sram_model i_mem (.mclk(MCLK), .muxed(muxed), .ale(ALE),
        .rd_n(RD_N), .wr_n(WR_N), .a_hi(ADDR_HI_O), .a_hi_oe(ADDR_HI_OE),
        .a_lo(ADDR_LO_O), .d_out(DATA_O), .d_in(DATA_I),
        .seen_addr(seen_addr));

    always #2.5 MCLK = ~MCLK;

    // strobe and latch cycle counters, plus hang guard
    always @(posedge MCLK) begin
        cycles++;
        if (RD_N === 1'b0 || WR_N === 1'b0) begin
            stb_cnt++;
        end
        if (ALE === 1'b1) begin
            ale_cnt++;
        end
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        SFR_ADDR <= a;
        SFR_WDATA <= d;
        SFR_WE <= 1'b1;
        @(posedge MCLK);
        SFR_WE <= 1'b0;
    endtask

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK);
        SFR_ADDR <= a;
        @(posedge MCLK);
        #1;
        d = SFR_RDATA;
    endtask

    task automatic acc(input logic wr, input logic wide,
                       input logic [15:0] a, input logic [7:0] wd,
                       output int n, output int sc, output int lc);
        int s0;
        int l0;
        @(posedge MCLK);
        CPU_REQ <= 1'b1;
        CPU_WR <= wr;
        CPU_WIDE <= wide;
        CPU_RI <= a[7:0];
        CPU_DATA_POINTER <= a;
        CPU_WDATA <= wd;
        @(posedge MCLK);
        CPU_REQ <= 1'b0;
        s0 = stb_cnt;
        l0 = ale_cnt;
        #1;
        n = 1;
        while (CPU_DONE !== 1'b1 && n < 60) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        sc = stb_cnt - s0;
        lc = ale_cnt - l0;
    endtask

    initial begin
        edm_row_s   r;
        int         n;
        int         sc;
        int         lc;
        logic [7:0] d;
        repeat (12) @(posedge MCLK);
        RST_N <= 1'b1;
        sfr_wr(PAGE_ADDR, 8'h20);
        sfr_wr(TC_ADDR, 8'h14);
        for (int i = 0; i < 8; i++) begin
            r = ROWS[i];
            sfr_wr(CFG_ADDR, r.cfg);
            muxed = ~r.cfg[4];
            acc(1'b1, r.wide, r.aw, 8'hA0 + 8'(i), n, sc, lc);
            chk(16'(n), r.off ? (muxed ? 16'd12 : 16'd10) : 16'd1);
            chk({15'h0, CPU_BUSY}, 16'h0001);
            chk(16'(sc), r.off ? 16'd6 : 16'd0);
            chk(16'(lc), (r.off && muxed) ? 16'd1 : 16'd0);
            if (r.off) begin
                chk(seen_addr, r.ea);
            end
            acc(1'b0, r.wide, r.ar, 8'h00, n, sc, lc);
            chk({8'h00, CPU_RDATA}, {8'h00, 8'hA0 + 8'(i)});
        end
        // second reset in mid-run
        @(posedge MCLK);
        RST_N <= 1'b0;
        #1;
        chk({9'h0, CPU_BUSY, ALE, RD_N, WR_N, DATA_OE, ADDR_LO_OE,
             ADDR_HI_OE}, 16'h0018);
        repeat (3) @(posedge MCLK);
        RST_N <= 1'b1;
        sfr_rd(TC_ADDR, d);
        chk({8'h00, d}, {8'h00, TC_RESET});
        sfr_rd(CFG_ADDR, d);
        chk({8'h00, d}, {8'h00, CFG_RESET});
        sfr_rd(8'h55, d);
        chk({8'h00, d}, 16'h0000);
        sfr_wr(CFG_ADDR, 8'hFF);
        sfr_rd(CFG_ADDR, d);
        chk({8'h00, d}, 16'h001F);
        sfr_wr(PAGE_ADDR, 8'h30);
        for (int i = 0; i < 5; i++) begin
            sfr_wr(TC_ADDR, TT[i]);
            sfr_wr(CFG_ADDR, TF[i]);
            muxed = ~TF[i][4];
            acc(1'b1, 1'b1, 16'h4000 + 16'(i), 8'h3C, n, sc, lc);
            chk(16'(n), 16'(TN[i]));
            chk(16'(sc), 16'(TS[i]));
            chk(16'(lc), 16'(TL[i]));
        end
        give_verdict();
    end
endmodule
`default_nettype wire
